// [design/cryctl_event.sv]
// module: gated event pulses with sticky status cleared by read
`default_nettype none
module cryctl_event #(
	parameter int N = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [N-1:0] cond,
	input wire logic [N-1:0] enable,
	input wire logic rd_clr,
	output logic [N-1:0] pulse,
	output logic [N-1:0] status_reg
);
	import cryctl_pkg::*;
	logic [N-1:0] prev_reg; // condition one cycle ago
	logic [N-1:0] status_next;
	// pulse only on the first cycle the condition is true
	assign pulse = cond & ~prev_reg & enable;
	// set wins over the read clear so no event is lost
	always_comb
	begin
		status_next = rd_clr ? '0 : status_reg;
		status_next = status_next | pulse;
	end
	// state registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_reg <= '0;
			status_reg <= '0;
		end
		else
		begin
			prev_reg <= cond;
			status_reg <= status_next;
		end
	end
endmodule : cryctl_event
`default_nettype wire

// [design/cryctl_top.sv]
// module: crypto engine control register, event logic and AXI4-Lite slave
// Function
// - bit 15 enables the engine
// - bit 13 halts engine during CPU idle
// - idle with halt set abandons operation
// - bit 12 enables counter rollover event
// - bit 11 enables operation done event
// - bit 10 enables input consumed event
// - go bit starts, hardware clears when done
// - software clearing go stops the operation
// - select fields locked while go set
// - reset clears control bits, disable mode all except bits 15 and 13
// - bits 14 and 9 read zero
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`default_nettype none
module cryctl_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_idle,
	input wire cryctl_pkg::cryctl_eng_in_t eng_in,
	output cryctl_pkg::cryctl_eng_out_t eng_out,
	output logic [2:0] event_pulse,
	output logic irq
);
	import cryctl_pkg::*;

	// register state
	logic [15:0] ctrl_reg, ctrl_next; // crypto_control_low
	logic [2:0] mask_reg, mask_next; // event mask
	logic md_reg, md_next; // engine_disable_mode
	logic start_reg, start_next; // launch pulse
	logic abort_reg, abort_next; // abandon pulse
	// write channel capture
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [3:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	// read channel
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	// event plumbing
	logic [2:0] ev_cond;
	logic [2:0] ev_en;
	logic [2:0] status_reg;
	logic stat_rd; // status read handshake
	logic do_write; // both write halves present
	logic idle_halt; // idle stop in force
	logic go_now;

	// byte-lane merge of a 16-bit register word
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		lane_merge = old;
		if (s[0])
			lane_merge[7:0] = d[7:0];
		if (s[1])
			lane_merge[15:8] = d[15:8];
	endfunction : lane_merge

	// decode of a mapped offset
	function automatic logic addr_ok(input logic [3:0] a);
		addr_ok = (a == CRYCTL_OFF_CTRL) || (a == CRYCTL_OFF_STAT) ||
			(a == CRYCTL_OFF_MASK) || (a == CRYCTL_OFF_MODE);
	endfunction : addr_ok

	// handshake outputs
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign stat_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == CRYCTL_OFF_STAT);
	assign go_now = ctrl_reg[CRYCTL_B_GO];
	assign idle_halt = cpu_idle && ctrl_reg[CRYCTL_B_SIDL];

	// engine commands; run needs enable, go and no idle halt
	assign eng_out.run = ctrl_reg[CRYCTL_B_ON] && go_now && !idle_halt;
	assign eng_out.start = start_reg;
	assign eng_out.abort = abort_reg;
	assign eng_out.op = ctrl_reg[CRYCTL_B_OP+:4];
	assign eng_out.csel = ctrl_reg[CRYCTL_B_CSEL];
	assign eng_out.cvar = ctrl_reg[CRYCTL_B_CVAR+:3];

	// event sources and their enables
	assign ev_cond[CRYCTL_EV_ROLL] = eng_in.rollover;
	assign ev_cond[CRYCTL_EV_DONE] = eng_in.done && go_now;
	assign ev_cond[CRYCTL_EV_FREE] = eng_in.consumed && go_now;
	assign ev_en[CRYCTL_EV_ROLL] = ctrl_reg[CRYCTL_B_ROLL];
	assign ev_en[CRYCTL_EV_DONE] = ctrl_reg[CRYCTL_B_DONE];
	assign ev_en[CRYCTL_EV_FREE] = ctrl_reg[CRYCTL_B_FREE];

	// sticky status with read clear
	cryctl_event #(.N(CRYCTL_NEV)) u_event (
		.aclk(aclk),
		.aresetn(aresetn),
		.cond(ev_cond),
		.enable(ev_en),
		.rd_clr(stat_rd),
		.pulse(event_pulse),
		.status_reg(status_reg)
	);

	// level interrupt while any unmasked status bit stands
	assign irq = |(status_reg & mask_reg);

	// control register and write channel next state
	always_comb
	begin
		logic [15:0] wv;
		wv = '0;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		md_next = md_reg;
		start_next = 1'b0;
		abort_next = 1'b0;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		// capture address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		// hardware completion clears go
		if (go_now && eng_in.done)
			ctrl_next[CRYCTL_B_GO] = 1'b0;
		// idle with halt selected abandons, not pauses
		if (go_now && idle_halt)
		begin
			ctrl_next[CRYCTL_B_GO] = 1'b0;
			abort_next = 1'b1;
		end
		// register write once both halves are in
		if (do_write)
		begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = addr_ok(awaddr_reg) ? CRYCTL_RESP_OK : CRYCTL_RESP_ERR;
			case (awaddr_reg)
				CRYCTL_OFF_CTRL:
				begin
					wv = lane_merge(ctrl_reg, wdata_reg, wstrb_reg) & CRYCTL_WMASK;
					// select fields frozen while an operation runs
					if (go_now)
						wv[7:0] = ctrl_reg[7:0];
					// go edge decides start or stop
					if (wv[CRYCTL_B_GO] && !go_now)
						start_next = 1'b1;
					else if (!wv[CRYCTL_B_GO] && go_now)
						abort_next = 1'b1;
					// a completion in this cycle still ends the run
					if (go_now && (eng_in.done || idle_halt))
						wv[CRYCTL_B_GO] = 1'b0;
					ctrl_next = wv;
				end
				CRYCTL_OFF_MASK:
				begin
					if (wstrb_reg[0])
						mask_next = wdata_reg[2:0];
				end
				CRYCTL_OFF_MODE:
				begin
					if (wstrb_reg[0])
						md_next = wdata_reg[CRYCTL_B_MD];
				end
				default:
				begin
					// status is read-only; unmapped answered with error
				end
			endcase
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_next = 1'b0;
		// disable mode holds event enables, go and selects at zero
		if (md_next)
		begin
			ctrl_next[CRYCTL_B_ROLL] = 1'b0;
			ctrl_next[CRYCTL_B_DONE] = 1'b0;
			ctrl_next[CRYCTL_B_FREE] = 1'b0;
			ctrl_next[CRYCTL_B_GO] = 1'b0;
			ctrl_next[7:0] = 8'h00;
			start_next = 1'b0;
		end
	end

	// read channel next state
	always_comb
	begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next = addr_ok(s_axi_araddr) ? CRYCTL_RESP_OK : CRYCTL_RESP_ERR;
			case (s_axi_araddr)
				CRYCTL_OFF_CTRL: rdata_next = {16'h0000, ctrl_reg & CRYCTL_WMASK};
				CRYCTL_OFF_STAT: rdata_next = {29'h0, status_reg};
				CRYCTL_OFF_MASK: rdata_next = {29'h0, mask_reg};
				CRYCTL_OFF_MODE: rdata_next = {29'h0, idle_halt, eng_in.busy, md_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		else if (s_axi_rready && rvalid_reg)
			rvalid_next = 1'b0;
	end

	// registers only; synchronous reset to constants
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= CRYCTL_RST_CTRL;
			mask_reg <= CRYCTL_RST_MASK;
			md_reg <= 1'b0;
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= CRYCTL_RESP_OK;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= CRYCTL_RESP_OK;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			md_reg <= md_next;
			start_reg <= start_next;
			abort_reg <= abort_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// checks on control behaviour
	AST_RUN_NEEDS_ON: assert property (@(posedge aclk) disable iff (!aresetn)
		eng_out.run |-> ctrl_reg[CRYCTL_B_ON])
		else $error("engine runs while disabled");
	AST_IDLE_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		(cpu_idle && ctrl_reg[CRYCTL_B_SIDL]) |-> !eng_out.run)
		else $error("engine runs in idle with halt set");
	AST_IDLE_ABANDON: assert property (@(posedge aclk) disable iff (!aresetn)
		(go_now && cpu_idle && ctrl_reg[CRYCTL_B_SIDL]) |=> (eng_out.abort && !go_now))
		else $error("idle halt did not abandon");
	AST_ROLL_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
		event_pulse[CRYCTL_EV_ROLL] |-> (ctrl_reg[CRYCTL_B_ROLL] && eng_in.rollover))
		else $error("rollover event without enable");
	AST_DONE_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
		(go_now && eng_in.done && ctrl_reg[CRYCTL_B_DONE] && !$past(eng_in.done))
		|-> event_pulse[CRYCTL_EV_DONE])
		else $error("done event missing");
	AST_FREE_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
		event_pulse[CRYCTL_EV_FREE] |-> ctrl_reg[CRYCTL_B_FREE])
		else $error("consumed event without enable");
	AST_GO_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		(go_now && eng_in.done) |=> !go_now)
		else $error("go not cleared on completion");
	AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(go_now) && !$past(eng_in.done) && !$past(idle_halt) && !$past(md_next))
		|-> eng_out.abort)
		else $error("stop without abort");
	AST_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		(go_now && !md_next) |=> $stable(ctrl_reg[7:0]))
		else $error("select fields changed while running");
	AST_MD_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		md_reg |-> (ctrl_reg[12:0] == 13'h0000))
		else $error("disable mode left control bits set");
	AST_UNIMPL: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg[14] == 1'b0) && (ctrl_reg[9] == 1'b0))
		else $error("unimplemented bit set");
	AST_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
		event_pulse[CRYCTL_EV_ROLL] |=> !event_pulse[CRYCTL_EV_ROLL])
		else $error("event longer than one cycle");
	COV_START: cover property (@(posedge aclk) disable iff (!aresetn) eng_out.start);
	COV_DONE: cover property (@(posedge aclk) disable iff (!aresetn)
		go_now ##[1:50] event_pulse[CRYCTL_EV_DONE]);
	COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq ##1 stat_rd);
endmodule : cryctl_top
`default_nettype wire

// [include/cryctl_pkg.sv]
// package: register map, field layout and engine carrier types of the crypto control block
`default_nettype none
package cryctl_pkg;
	// byte offsets of the registers
	localparam logic [3:0] CRYCTL_OFF_CTRL = 4'h0; // crypto_control_low
	localparam logic [3:0] CRYCTL_OFF_STAT = 4'h4; // sticky event status
	localparam logic [3:0] CRYCTL_OFF_MASK = 4'h8; // event mask
	localparam logic [3:0] CRYCTL_OFF_MODE = 4'hC; // disable mode and engine state
	// control field positions
	localparam int CRYCTL_B_ON = 15;
	localparam int CRYCTL_B_SIDL = 13;
	localparam int CRYCTL_B_ROLL = 12;
	localparam int CRYCTL_B_DONE = 11;
	localparam int CRYCTL_B_FREE = 10;
	localparam int CRYCTL_B_GO = 8;
	localparam int CRYCTL_B_OP = 4;
	localparam int CRYCTL_B_CSEL = 3;
	localparam int CRYCTL_B_CVAR = 0;
	// mode register positions
	localparam int CRYCTL_B_MD = 0;
	localparam int CRYCTL_B_BSY = 1;
	localparam int CRYCTL_B_HALT = 2;
	// event numbering in status and mask
	localparam int CRYCTL_EV_ROLL = 0;
	localparam int CRYCTL_EV_DONE = 1;
	localparam int CRYCTL_EV_FREE = 2;
	localparam int CRYCTL_NEV = 3;
	// reset values
	localparam logic [15:0] CRYCTL_RST_CTRL = 16'h0000;
	localparam logic [2:0] CRYCTL_RST_MASK = 3'h0;
	// bits that take writes; 14 and 9 are unimplemented
	localparam logic [15:0] CRYCTL_WMASK = 16'hBDFF;
	localparam logic [1:0] CRYCTL_RESP_OK = 2'h0;
	localparam logic [1:0] CRYCTL_RESP_ERR = 2'h2;
	// commands and fields toward the cipher datapath
	typedef struct packed {
		logic run; // datapath may advance
		logic start; // one-cycle launch
		logic abort; // one-cycle abandon
		logic [3:0] op; // operation_select
		logic csel; // cipher_engine_select
		logic [2:0] cvar; // cipher_variant_select
	} cryctl_eng_out_t;
	// reports from the cipher datapath, same clock
	typedef struct packed {
		logic busy; // engine_busy_flag
		logic done; // operation complete
		logic consumed; // input text taken
		logic rollover; // text_block_b counter wrapped
	} cryctl_eng_in_t;
endpackage : cryctl_pkg
`default_nettype wire

// [verif/tb_crypto_engine_control.sv]
// testbench: register, engine control and event checks of the crypto control block
`default_nettype none
module tb_crypto_engine_control;
	timeunit 1ns;
	timeprecision 1ps;
	import cryctl_pkg::*;
	logic aclk = 1'b0; // 125 MHz system clock
	logic aresetn = 1'b0; // synchronous, active low
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic cpu_idle = 1'b0; // cpu idle level
	cryctl_eng_in_t eng_in = '0; // datapath reports
	cryctl_eng_out_t eng_out;
	logic [2:0] event_pulse;
	int num_errors = 0, checks_done = 0, cyc = 0;
	int ev_cnt[3] = '{0, 0, 0}; // pulses seen per event
	int n_start = 0, n_abort = 0; // launch and abandon pulses seen
	logic [31:0] rd; // last read value
	logic [1:0] rs; // last response
	cryctl_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cpu_idle(cpu_idle), .eng_in(eng_in), .eng_out(eng_out),
		.event_pulse(event_pulse), .irq(irq));
	// free running clock
	always #4 aclk = ~aclk;
	// pulse counters sample mid-cycle, so a task sees the count at the next rising edge
	always @(negedge aclk)
	begin
		if (aresetn)
		begin
			for (int i = 0; i < 3; i++) ev_cnt[i] <= ev_cnt[i] + int'(event_pulse[i]);
			n_start <= n_start + int'(eng_out.start);
			n_abort <= n_abort + int'(eng_out.abort);
		end
	end
	// cycle count and hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			num_errors++; // hang guard
			tally_and_finish();
		end
	end
	// compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// write one word; handshakes judged at the falling edge, released after the rising one
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		bit aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(negedge aclk);
			if (awvalid && awready) aw_d = 1;
			if (wvalid && wready) w_d = 1;
			if (bvalid)
			begin
				rs = bresp;
				@(posedge aclk);
				bready <= 1'b0;
				break;
			end
			@(posedge aclk);
			if (aw_d) awvalid <= 1'b0;
			if (w_d) wvalid <= 1'b0;
		end
	endtask : axi_wr
	// read one word; rready held until rvalid is seen
	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(negedge aclk);
			if (rvalid)
			begin
				rd = rdata;
				rs = rresp;
				@(posedge aclk);
				rready <= 1'b0;
				break;
			end
			if (arready)
			begin
				@(posedge aclk);
				arvalid <= 1'b0;
			end
		end
	endtask : axi_rd
	// hold a datapath report for n cycles
	task automatic drive_in(input logic [3:0] v, input int n);
		@(posedge aclk);
		eng_in <= cryctl_eng_in_t'(v);
		repeat (n) @(posedge aclk);
		eng_in <= '0;
		repeat (3) @(posedge aclk);
	endtask : drive_in
	// reset values, unimplemented bits, unmapped address
	task automatic t_regs();
		axi_rd(CRYCTL_OFF_CTRL);
		chk("ctrl reset", rd, 32'h0);
		axi_rd(CRYCTL_OFF_MASK);
		chk("mask reset", rd, 32'h0);
		axi_wr(CRYCTL_OFF_CTRL, 32'h0000FEFF);
		axi_rd(CRYCTL_OFF_CTRL);
		chk("ctrl unimpl", rd, 32'h0000BCFF);
		chk("eng fields", {20'h0, eng_out.op, eng_out.csel, eng_out.cvar}, 32'hFF);
		axi_wr(4'h2, 32'h0000FFFF);
		chk("unmapped wr resp", {30'h0, rs}, {30'h0, CRYCTL_RESP_ERR});
		axi_rd(4'h2);
		chk("unmapped rd resp", {30'h0, rs}, {30'h0, CRYCTL_RESP_ERR});
		$display("test regs done");
	endtask : t_regs
	// start, field lock and software stop
	task automatic t_lock();
		int s0, a0;
		s0 = n_start;
		a0 = n_abort;
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008135);
		chk("start pulses", n_start - s0, 1);
		axi_wr(CRYCTL_OFF_CTRL, 32'h000081CA);
		axi_rd(CRYCTL_OFF_CTRL);
		chk("ctrl locked", rd, 32'h00008135);
		chk("run", {31'h0, eng_out.run}, 32'h1);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008035);
		axi_rd(CRYCTL_OFF_CTRL);
		chk("ctrl stopped", rd, 32'h00008035);
		chk("abort pulses", n_abort - a0, 1);
		$display("test lock done");
	endtask : t_lock
	// completion clears go, raises done event and interrupt
	task automatic t_done();
		int e0;
		axi_wr(CRYCTL_OFF_MASK, 32'h7);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008900);
		e0 = ev_cnt[1];
		drive_in(4'h4, 3);
		chk("done pulses", ev_cnt[1] - e0, 1);
		chk("irq on", {31'h0, irq}, 32'h1);
		axi_rd(CRYCTL_OFF_CTRL);
		chk("go hw clear", rd, 32'h00008800);
		axi_rd(CRYCTL_OFF_STAT);
		chk("status done", rd, 32'h2);
		axi_rd(CRYCTL_OFF_STAT);
		chk("status cleared", rd, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		$display("test done done");
	endtask : t_done
	// consumed and rollover, each with its enable off then on
	task automatic t_events();
		int e0;
		axi_wr(CRYCTL_OFF_MASK, 32'h2);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008100);
		e0 = ev_cnt[2];
		drive_in(4'h2, 3);
		chk("consumed off", ev_cnt[2] - e0, 0);
		drive_in(4'h1, 2);
		chk("roll off", ev_cnt[0], 0);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00009500);
		drive_in(4'h2, 3);
		chk("consumed on", ev_cnt[2] - e0, 1);
		drive_in(4'h1, 3);
		chk("roll on", ev_cnt[0], 1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		axi_rd(CRYCTL_OFF_STAT);
		chk("status ev", rd, 32'h5);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008000);
		$display("test events done");
	endtask : t_events
	// idle halt abandons, idle continue keeps running
	task automatic t_idle();
		int a0;
		axi_wr(CRYCTL_OFF_CTRL, 32'h0000A135);
		a0 = n_abort;
		@(posedge aclk);
		cpu_idle <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("run idle halt", {31'h0, eng_out.run}, 32'h0);
		cpu_idle <= 1'b0;
		axi_rd(CRYCTL_OFF_CTRL);
		chk("go abandoned", rd, 32'h0000A035);
		chk("idle abort", n_abort - a0, 1);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008135);
		cpu_idle <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("run idle keep", {31'h0, eng_out.run}, 32'h1);
		cpu_idle <= 1'b0;
		axi_rd(CRYCTL_OFF_CTRL);
		chk("go kept", rd, 32'h00008135);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00008035);
		$display("test idle done");
	endtask : t_idle
	// disable mode clears event enables, go and selects
	task automatic t_mode();
		axi_wr(CRYCTL_OFF_CTRL, 32'h0000BD35);
		axi_wr(CRYCTL_OFF_MODE, 32'h1);
		axi_rd(CRYCTL_OFF_CTRL);
		chk("ctrl disabled", rd, 32'h0000A000);
		axi_rd(CRYCTL_OFF_MODE);
		chk("mode readback", rd, 32'h1);
		axi_wr(CRYCTL_OFF_MODE, 32'h0);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00000100);
		chk("run while off", {31'h0, eng_out.run}, 32'h0);
		axi_wr(CRYCTL_OFF_CTRL, 32'h00000000);
		$display("test mode done");
	endtask : t_mode
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_lock();
		t_done();
		t_events();
		t_idle();
		t_mode();
		tally_and_finish();
	end
endmodule : tb_crypto_engine_control
`default_nettype wire
